// ==== inc/ptm_pkg.sv ====
package ptm_pkg;
    localparam logic [7:0] ADDR_CTRL0 = 8'h00;
    localparam logic [7:0] ADDR_CTRL1 = 8'h04;
    localparam logic [7:0] ADDR_CNT_LO = 8'h08;
    localparam logic [7:0] ADDR_CNT_HI = 8'h0C;
    localparam logic [7:0] ADDR_CMPA_LO = 8'h10;
    localparam logic [7:0] ADDR_CMPA_HI = 8'h14;
    localparam logic [7:0] ADDR_PER_LO = 8'h18;
    localparam logic [7:0] ADDR_PER_HI = 8'h1C;
    localparam logic [7:0] ADDR_FLAGS = 8'h20;
    localparam int RUN_BIT = 3;
    localparam int MODE_POS = 6;
    localparam int PIN_POS = 4;
    localparam int OLC_BIT = 3;
    localparam int INV_BIT = 2;
    localparam int CLR_BIT = 0;
    localparam int FLAG_A_BIT = 0;
    localparam int FLAG_P_BIT = 1;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [15:0] CMP_RESET = 16'h0000;
    localparam logic [1:0] MODE_CMP = 2'h0;
    localparam logic [1:0] MODE_PWM = 2'h2;
    localparam logic [1:0] MODE_TC = 2'h3;
    localparam logic [1:0] PIN_LOW = 2'h1;
    localparam logic [1:0] PIN_HIGH = 2'h2;
    localparam logic [1:0] PIN_ACT = 2'h1;
    localparam logic [1:0] PIN_PWM = 2'h2;
    localparam logic [1:0] PIN_SPULSE = 2'h3;

    typedef struct packed {
        logic [1:0] mode;
        logic [1:0] pin_action;
        logic output_level_control;
        logic output_invert;
        logic reserved;
        logic clear_source_select;
    } ptm_ctrl1_t;
endpackage

// ==== core/ptm_timer.sv ====
`timescale 1ns/100ps
// What this block does
// - Mode field picks compare, counter, PWM; PWM with pin action 11 is pulse
// - Compare, clear-on-P: clear on P, both flags
// - Compare, clear-on-A: clear on A, no P
// - Compare-A zero: overflow at FFFF, no A flag
// - Compare pin changes only on compare-A match or run rise
// - Compare pin action zero leaves pin unchanged; in PWM it forces the idle level
// - Run rising edge loads initial pin level
// - Counter mode counts like compare, pin released
// - PWM clears on period, duty from A
// - Period value zero gives 65536 counts
// - Duty at or above period is full
// - PWM raises A and P flags
// - PWM polarity, pin action, invert shape output
// - Forced pin levels keep PWM counting
// - Pulse: run rise starts count, leading edge
// - Pulse: trigger pin edge sets run bit
// - Pulse ends on run clear or A match
// - Pulse: counter resets only on run rise
// - Compare values split into byte registers
// - Run rise zeroes counter, fall holds it
// - Compare match: 01 low, 10 high, 11 toggle
module ptm_timer (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic external_clock_trigger_pin,
    output logic timer_out,
    output logic timer_out_en_n
);
    logic [7:0] ctrl0_q;
    ptm_pkg::ptm_ctrl1_t ctrl1_q;
    logic [15:0] compare_a_value_q;
    logic [15:0] period_value_q;
    logic [15:0] count_q;
    logic match_a_flag_q;
    logic match_p_flag_q;
    logic pin_q;
    logic run_prev_q;
    logic trig_s1_q, trig_s2_q, trig_s3_q;
    logic counter_run;
    logic wr, rd, run_rise;
    logic pulse_mode, pwm_mode, cmp_like;
    logic match_a, match_p, clr_a, clr_p;
    logic [15:0] wbyte_ext;
    logic [15:0] a_tgt, p_tgt;
    logic [1:0] pin_act;

    assign wr = psel & penable & pwrite;
    assign rd = psel & penable & ~pwrite;
    assign counter_run = ctrl0_q[ptm_pkg::RUN_BIT];
    assign run_rise = counter_run & ~run_prev_q;
    assign pin_act = ctrl1_q.pin_action;
    assign cmp_like = (ctrl1_q.mode == ptm_pkg::MODE_CMP) ||
                      (ctrl1_q.mode == ptm_pkg::MODE_TC);
    assign pwm_mode = (ctrl1_q.mode == ptm_pkg::MODE_PWM) &&
                      (pin_act != ptm_pkg::PIN_SPULSE);
    assign pulse_mode = (ctrl1_q.mode == ptm_pkg::MODE_PWM) &&
                        (pin_act == ptm_pkg::PIN_SPULSE);
    assign wbyte_ext = {8'h00, pwdata[7:0]};

    // PWM compares one count early so period and duty are exact
    assign a_tgt = pwm_mode ? (compare_a_value_q - 16'h0001)
                            : compare_a_value_q;
    assign p_tgt = pwm_mode ? (period_value_q - 16'h0001)
                            : period_value_q;

    // Comparators only fire on a counting cycle
    assign match_a = counter_run && !run_rise &&
                     (compare_a_value_q != 16'h0000) &&
                     (count_q == a_tgt);
    assign match_p = counter_run && !run_rise &&
                     (count_q == p_tgt) &&
                     (pwm_mode || period_value_q != 16'h0000);
    assign clr_a = cmp_like && ctrl1_q.clear_source_select && match_a;
    assign clr_p = (pwm_mode || (cmp_like && !ctrl1_q.clear_source_select))
                   && match_p;

    // Trigger pin synchroniser
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            trig_s1_q <= 1'b0;
            trig_s2_q <= 1'b0;
            trig_s3_q <= 1'b0;
        end else begin
            trig_s1_q <= external_clock_trigger_pin;
            trig_s2_q <= trig_s1_q;
            trig_s3_q <= trig_s2_q;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            run_prev_q <= 1'b0;
        end else begin
            run_prev_q <= counter_run;
        end
    end

    // Control register 0 with run bit
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl0_q <= ptm_pkg::CTRL_RESET;
        end else begin
            if (wr && paddr == ptm_pkg::ADDR_CTRL0) begin
                ctrl0_q <= {pwdata[7:3], 3'h0};
            end
            if (pulse_mode && trig_s2_q && !trig_s3_q) begin
                ctrl0_q[ptm_pkg::RUN_BIT] <= 1'b1;
            end else if (pulse_mode && match_a) begin
                ctrl0_q[ptm_pkg::RUN_BIT] <= 1'b0;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl1_q <= ptm_pkg::CTRL_RESET;
        end else if (wr && paddr == ptm_pkg::ADDR_CTRL1) begin
            ctrl1_q <= {pwdata[7:2], 1'b0, pwdata[0]};
        end
    end

    // Byte-split compare values
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            compare_a_value_q <= ptm_pkg::CMP_RESET;
            period_value_q <= ptm_pkg::CMP_RESET;
        end else if (wr) begin
            case (paddr)
                ptm_pkg::ADDR_CMPA_LO:
                    compare_a_value_q[7:0] <= wbyte_ext[7:0];
                ptm_pkg::ADDR_CMPA_HI:
                    compare_a_value_q[15:8] <= wbyte_ext[7:0];
                ptm_pkg::ADDR_PER_LO:
                    period_value_q[7:0] <= wbyte_ext[7:0];
                ptm_pkg::ADDR_PER_HI:
                    period_value_q[15:8] <= wbyte_ext[7:0];
                default: begin
                end
            endcase
        end
    end

    // Counter
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_q <= 16'h0000;
        end else if (run_rise) begin
            count_q <= 16'h0000;
        end else if (counter_run) begin
            if (!pulse_mode && (clr_a || clr_p)) begin
                count_q <= 16'h0000;
            end else begin
                count_q <= count_q + 16'h0001;
            end
        end
    end

    // Sticky flags, write one to clear, set wins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            match_a_flag_q <= 1'b0;
            match_p_flag_q <= 1'b0;
        end else begin
            if (match_a) begin
                match_a_flag_q <= 1'b1;
            end else if (wr && paddr == ptm_pkg::ADDR_FLAGS &&
                         pwdata[ptm_pkg::FLAG_A_BIT]) begin
                match_a_flag_q <= 1'b0;
            end
            if (match_p && !pulse_mode &&
                !(cmp_like && ctrl1_q.clear_source_select)) begin
                match_p_flag_q <= 1'b1;
            end else if (wr && paddr == ptm_pkg::ADDR_FLAGS &&
                         pwdata[ptm_pkg::FLAG_P_BIT]) begin
                match_p_flag_q <= 1'b0;
            end
        end
    end

    // Output pin level before polarity
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_q <= 1'b0;
        end else if (ctrl1_q.mode == ptm_pkg::MODE_CMP) begin
            if (run_rise) begin
                pin_q <= ctrl1_q.output_level_control;
            end else if (match_a) begin
                case (pin_act)
                    ptm_pkg::PIN_LOW: pin_q <= 1'b0;
                    ptm_pkg::PIN_HIGH: pin_q <= 1'b1;
                    ptm_pkg::PIN_SPULSE: pin_q <= ~pin_q;
                    default: pin_q <= pin_q;
                endcase
            end
        end else if (pwm_mode) begin
            case (pin_act)
                ptm_pkg::PIN_PWM: begin
                    if (run_rise || clr_p ||
                        (period_value_q == 16'h0000 && count_q == 16'hFFFF
                         && counter_run)) begin
                        pin_q <= (compare_a_value_q != 16'h0000) ?
                                 ctrl1_q.output_level_control :
                                 ~ctrl1_q.output_level_control;
                    end else if (match_a && (period_value_q == 16'h0000 ||
                                 compare_a_value_q < period_value_q)) begin
                        pin_q <= ~ctrl1_q.output_level_control;
                    end
                end
                ptm_pkg::PIN_ACT: pin_q <= ctrl1_q.output_level_control;
                default: pin_q <= ~ctrl1_q.output_level_control;
            endcase
        end else if (pulse_mode) begin
            if (run_rise) begin
                pin_q <= ctrl1_q.output_level_control;
            end else if (!counter_run) begin
                pin_q <= ~ctrl1_q.output_level_control;
            end
        end
    end

    // Pin driver registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            timer_out <= 1'b0;
            timer_out_en_n <= 1'b1;
        end else begin
            timer_out <= pin_q ^ ctrl1_q.output_invert;
            timer_out_en_n <= (ctrl1_q.mode == ptm_pkg::MODE_TC);
        end
    end

    // APB read path, zero wait states
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            case (paddr)
                ptm_pkg::ADDR_CTRL0: prdata <= {24'h0, ctrl0_q};
                ptm_pkg::ADDR_CTRL1: prdata <= {24'h0, ctrl1_q};
                ptm_pkg::ADDR_CNT_LO: prdata <= {24'h0, count_q[7:0]};
                ptm_pkg::ADDR_CNT_HI: prdata <= {24'h0, count_q[15:8]};
                ptm_pkg::ADDR_CMPA_LO:
                    prdata <= {24'h0, compare_a_value_q[7:0]};
                ptm_pkg::ADDR_CMPA_HI:
                    prdata <= {24'h0, compare_a_value_q[15:8]};
                ptm_pkg::ADDR_PER_LO: prdata <= {24'h0, period_value_q[7:0]};
                ptm_pkg::ADDR_PER_HI: prdata <= {24'h0, period_value_q[15:8]};
                ptm_pkg::ADDR_FLAGS:
                    prdata <= {30'h0, match_p_flag_q, match_a_flag_q};
                default: prdata <= 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= psel && !penable;
            pslverr <= psel && !penable && (paddr > ptm_pkg::ADDR_FLAGS ||
                       paddr[1:0] != 2'h0);
        end
    end

    a_run_zero: assert property (@(posedge pclk) disable iff (!presetn)
        run_rise |=> count_q == 16'h0000)
        else $error("counter not zeroed on run rise");
    a_hold_stop: assert property (@(posedge pclk) disable iff (!presetn)
        !counter_run && !$past(counter_run) |=> $stable(count_q))
        else $error("counter moved while stopped");
    a_no_pflag: assert property (@(posedge pclk) disable iff (!presetn)
        cmp_like && ctrl1_q.clear_source_select && !match_p_flag_q
        |=> !match_p_flag_q || $past(wr))
        else $error("P flag raised with clear on A");
    a_aflag_set: assert property (@(posedge pclk) disable iff (!presetn)
        match_a |=> match_a_flag_q)
        else $error("A flag not set");
    a_pflag_set: assert property (@(posedge pclk) disable iff (!presetn)
        match_p && pwm_mode |=> match_p_flag_q)
        else $error("P flag not set in PWM");
    a_clr_p: assert property (@(posedge pclk) disable iff (!presetn)
        clr_p && !run_rise |=> count_q == 16'h0000)
        else $error("counter not cleared on P");
    a_init_lvl: assert property (@(posedge pclk) disable iff (!presetn)
        run_rise && ctrl1_q.mode == ptm_pkg::MODE_CMP
        |=> pin_q == $past(ctrl1_q.output_level_control))
        else $error("pin not at initial level");
    a_pulse_end: assert property (@(posedge pclk) disable iff (!presetn)
        pulse_mode && match_a && !(trig_s2_q && !trig_s3_q)
        |=> !counter_run)
        else $error("run bit not cleared by A match");
    a_tc_float: assert property (@(posedge pclk) disable iff (!presetn)
        ctrl1_q.mode == ptm_pkg::MODE_TC |=> timer_out_en_n)
        else $error("pin driven in counter mode");
    a_no_p_pin: assert property (@(posedge pclk) disable iff (!presetn)
        ctrl1_q.mode == ptm_pkg::MODE_CMP && !match_a && !run_rise
        |=> $stable(pin_q))
        else $error("pin changed without A match");
    a_ovf_wrap: assert property (
        @(posedge pclk) disable iff (!presetn) cmp_like && counter_run &&
        !run_rise && period_value_q == 16'h0000 && count_q == 16'hFFFF
        && !clr_a |=> count_q == 16'h0000) else $error("no wrap at top");
    a_pin_keep: assert property (
        @(posedge pclk) disable iff (!presetn) ctrl1_q.mode ==
        ptm_pkg::MODE_CMP && pin_act == 2'h0 && !run_rise |=> $stable(pin_q))
        else $error("pin moved with no action");
    a_pin_low: assert property (
        @(posedge pclk) disable iff (!presetn) ctrl1_q.mode ==
        ptm_pkg::MODE_CMP && match_a && pin_act == ptm_pkg::PIN_LOW
        |=> !pin_q) else $error("pin not driven low");
    a_pin_high: assert property (
        @(posedge pclk) disable iff (!presetn) ctrl1_q.mode ==
        ptm_pkg::MODE_CMP && match_a && pin_act == ptm_pkg::PIN_HIGH
        |=> pin_q) else $error("pin not driven high");
    a_pin_toggle: assert property (
        @(posedge pclk) disable iff (!presetn) ctrl1_q.mode ==
        ptm_pkg::MODE_CMP && match_a && pin_act == ptm_pkg::PIN_SPULSE
        |=> pin_q != $past(pin_q)) else $error("pin not toggled");
    a_pwm_wrap: assert property (
        @(posedge pclk) disable iff (!presetn) pwm_mode && counter_run &&
        !run_rise && period_value_q == 16'h0000 && count_q == 16'hFFFF
        |=> count_q == 16'h0000) else $error("PWM wrap wrong");
    a_full_duty: assert property (
        @(posedge pclk) disable iff (!presetn) pwm_mode && pin_act ==
        ptm_pkg::PIN_PWM && compare_a_value_q >= period_value_q &&
        period_value_q != 16'h0000 && pin_q == ctrl1_q.output_level_control
        |=> pin_q == $past(ctrl1_q.output_level_control))
        else $error("full duty lost");
    a_pwm_duty: assert property (
        @(posedge pclk) disable iff (!presetn) pwm_mode && pin_act ==
        ptm_pkg::PIN_PWM && match_a && !clr_p && period_value_q != 16'h0000
        && compare_a_value_q < period_value_q
        |=> pin_q == !$past(ctrl1_q.output_level_control))
        else $error("duty edge missing");
    a_force_act: assert property (
        @(posedge pclk) disable iff (!presetn) pwm_mode && pin_act ==
        ptm_pkg::PIN_ACT |=> pin_q == $past(ctrl1_q.output_level_control))
        else $error("forced active level wrong");
    a_force_idle: assert property (
        @(posedge pclk) disable iff (!presetn) pwm_mode && pin_act == 2'h0
        |=> pin_q == !$past(ctrl1_q.output_level_control))
        else $error("forced idle level wrong");
    a_force_count: assert property (
        @(posedge pclk) disable iff (!presetn) pwm_mode && pin_act !=
        ptm_pkg::PIN_PWM && counter_run && !run_rise && !clr_p
        |=> count_q == $past(count_q) + 16'h0001) else $error("PWM halted");
    a_pin_inv: assert property (
        @(posedge pclk) disable iff (!presetn) 1'b1
        |=> timer_out == $past(pin_q ^ ctrl1_q.output_invert))
        else $error("output polarity wrong");
    a_pulse_lead: assert property (
        @(posedge pclk) disable iff (!presetn) pulse_mode && run_rise
        |=> pin_q == $past(ctrl1_q.output_level_control))
        else $error("pulse leading edge missing");
    a_pulse_trig: assert property (
        @(posedge pclk) disable iff (!presetn) pulse_mode && trig_s2_q &&
        !trig_s3_q |=> counter_run) else $error("trigger did not start");
    a_pulse_count: assert property (
        @(posedge pclk) disable iff (!presetn) pulse_mode && counter_run &&
        !run_rise |=> count_q == $past(count_q) + 16'h0001)
        else $error("pulse counter cleared");
    a_byte_lo: assert property (
        @(posedge pclk) disable iff (!presetn) wr && paddr ==
        ptm_pkg::ADDR_CMPA_LO |=> compare_a_value_q[7:0] ==
        $past(pwdata[7:0])) else $error("low byte not stored");
    a_byte_hi: assert property (
        @(posedge pclk) disable iff (!presetn) wr && paddr ==
        ptm_pkg::ADDR_PER_HI |=> period_value_q[15:8] ==
        $past(pwdata[7:0])) else $error("high byte not stored");
    a_cmp_pflag: assert property (
        @(posedge pclk) disable iff (!presetn) cmp_like &&
        !ctrl1_q.clear_source_select && match_p |=> match_p_flag_q)
        else $error("P flag not set");

    c_cmp_match: cover property (@(posedge pclk) match_a && cmp_like);
    c_pwm_wrap: cover property (@(posedge pclk) clr_p && pwm_mode);
    c_pulse_trig: cover property (@(posedge pclk)
        pulse_mode && trig_s2_q && !trig_s3_q);
    c_pulse_done: cover property (@(posedge pclk)
        pulse_mode && match_a);
    c_full_duty: cover property (@(posedge pclk)
        pwm_mode && clr_p && compare_a_value_q >= period_value_q);
endmodule // ptm_timer

// ==== tb/ptm_pin_model.sv ====
`timescale 1ns/100ps
module ptm_pin_model (
    input wire logic pclk,
    input wire logic timer_out,
    input wire logic timer_out_en_n,
    input wire logic trig_req,
    output logic external_clock_trigger_pin,
    output logic pin_level
);
    logic [2:0] hold_q = 3'h0;
    // Trigger edge held a few cycles
    always @(posedge pclk) begin
        if (trig_req) begin
            hold_q <= 3'h6;
        end else if (hold_q != 3'h0) begin
            hold_q <= hold_q - 3'h1;
        end
    end
    assign external_clock_trigger_pin = (hold_q != 3'h0);
    // Released pin falls to its pull-down
    assign pin_level = timer_out_en_n ? 1'b0 : timer_out;
endmodule // ptm_pin_model

// ==== tb/tb_top.sv ====
`timescale 1ns/100ps
module tb_top;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, trig = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd_v, r;
    logic pready, pslverr, timer_out, timer_out_en_n, ext_pin, pin, olc;
    logic [32:0] exp_q[$];
    logic [7:0] al [0:6] = '{ptm_pkg::ADDR_CTRL0, ptm_pkg::ADDR_CTRL1,
        ptm_pkg::ADDR_FLAGS, ptm_pkg::ADDR_CMPA_LO, ptm_pkg::ADDR_CMPA_HI,
        ptm_pkg::ADDR_PER_LO, ptm_pkg::ADDR_PER_HI};
    int miscompares = 0;
    int tests_run = 0;
    always #20 pclk = ~pclk;
    ptm_timer dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .external_clock_trigger_pin(ext_pin), .timer_out(timer_out),
        .timer_out_en_n(timer_out_en_n));
    ptm_pin_model pin_u (.pclk(pclk), .timer_out(timer_out),
        .timer_out_en_n(timer_out_en_n), .trig_req(trig),
        .external_clock_trigger_pin(ext_pin), .pin_level(pin));
    task automatic check(input logic [32:0] got, input logic [32:0] exp);
        tests_run++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic test_done;
        $display("comparisons %0d miscompares %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // Read results checked against oldest note
    always @(posedge pclk) begin
        if (psel && penable && pready === 1'b1 && !pwrite && exp_q.size() > 0) begin
            check({pslverr, prdata}, exp_q.pop_front());
        end
    end
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            miscompares++;
            test_done();
        end
        rd_v = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e,
        input logic er = 1'b0);
        exp_q.push_back({er, e});
        apb(1'b0, a, 32'h0);
    endtask
    task automatic wt(input int n);
        repeat (n) @(posedge pclk);
    endtask
    task automatic pchk(input logic v);
        check(33'(pin), 33'(v));
    endtask
    task automatic ld(input logic [15:0] a, input logic [15:0] p);
        wr(ptm_pkg::ADDR_CMPA_LO, {24'h0, a[7:0]});
        wr(ptm_pkg::ADDR_CMPA_HI, {24'h0, a[15:8]});
        wr(ptm_pkg::ADDR_PER_LO, {24'h0, p[7:0]});
        wr(ptm_pkg::ADDR_PER_HI, {24'h0, p[15:8]});
    endtask
    task automatic restart(input logic [31:0] c);
        wr(ptm_pkg::ADDR_CTRL0, 32'h0);
        wr(ptm_pkg::ADDR_FLAGS, 32'h3);
        wr(ptm_pkg::ADDR_CTRL1, c);
        wr(ptm_pkg::ADDR_CTRL0, 32'h8);
    endtask
    task automatic pwm(input logic [31:0] c, input int a, input int e,
        input logic [31:0] f);
        int h;
        h = 0;
        ld(16'(a), 16'h0014);
        restart(c);
        wt(10);
        wr(ptm_pkg::ADDR_FLAGS, 32'h3);
        repeat (40) begin
            @(posedge pclk);
            h += int'(pin);
        end
        check(33'(h), 33'(e));
        rd(ptm_pkg::ADDR_FLAGS, f);
    endtask
    initial begin
        void'($urandom(32'hC3816803));
        wt(6);
        presetn <= 1'b1;
        for (int i = 0; i < 7; i++) rd(al[i], 32'h0);
        for (int i = 3; i < 7; i++) begin
            r = $urandom;
            wr(al[i], r);
            rd(al[i], {24'h0, r[7:0]});
        end
        rd(8'h24, 32'h0, 1'b1);
        ld(16'h0014, 16'h0028);
        for (int p = 0; p < 4; p++) begin
            olc = (p == 1);
            restart({26'h0, 2'(p), olc, 3'h0});
            wt(3);
            pchk(olc);
            wt(30);
            pchk(p == 0 ? olc : ~olc);
            wt(10);
            rd(ptm_pkg::ADDR_FLAGS, 32'h3);
        end
        ld(16'h0014, 16'h000A);
        restart(32'h01);
        wt(60);
        rd(ptm_pkg::ADDR_FLAGS, 32'h1);
        ld(16'h0014, 16'h0028);
        restart(32'hC0);
        wt(50);
        rd(ptm_pkg::ADDR_FLAGS, 32'h3);
        check(33'(timer_out_en_n), 33'h1);
        ld(16'h0000, 16'h0000);
        restart(32'hC0);
        wt(100);
        rd(ptm_pkg::ADDR_FLAGS, 32'h0);
        wr(ptm_pkg::ADDR_CTRL0, 32'h0);
        apb(1'b0, ptm_pkg::ADDR_CNT_LO, 32'h0);
        r = rd_v;
        wt(20);
        rd(ptm_pkg::ADDR_CNT_LO, r);
        wr(ptm_pkg::ADDR_CTRL0, 32'h8);
        apb(1'b0, ptm_pkg::ADDR_CNT_LO, 32'h0);
        check(33'(rd_v < 32'h8), 33'h1);
        pwm(32'hA8, 5, 10, 32'h3);
        pwm(32'hAC, 5, 30, 32'h3);
        pwm(32'h88, 5, 0, 32'h3);
        pwm(32'h98, 5, 40, 32'h3);
        pwm(32'hA8, 25, 40, 32'h2);
        ld(16'h0014, 16'h0000);
        restart(32'hB8);
        wr(ptm_pkg::ADDR_CTRL0, 32'h0);
        wr(ptm_pkg::ADDR_FLAGS, 32'h3);
        for (int k = 0; k < 2; k++) begin
            if (k == 0) begin
                trig <= 1'b1;
                @(posedge pclk);
                trig <= 1'b0;
            end else begin
                wr(ptm_pkg::ADDR_CTRL0, 32'h8);
            end
            wt(8);
            rd(ptm_pkg::ADDR_CTRL0, 32'h8);
            pchk(1'b1);
            wt(30);
            rd(ptm_pkg::ADDR_CTRL0, 32'h0);
            pchk(1'b0);
            rd(ptm_pkg::ADDR_FLAGS, 32'h1);
            wr(ptm_pkg::ADDR_FLAGS, 32'h3);
        end
        wt(4);
        test_done();
    end
endmodule // tb_top
